// ---- src/sensor_config_word_fields.sv ----
// configuration field logic for word bits 54..16 of the sensor interface
// assumes: pins are asynchronous; cycle_start/end come from the
// measurement sequencer on the core clock
//
// Notes on behaviour
// - pump enable 0 turns source off and parks C3 near reference.
// - deferred fields wait pending until the next measurement cycle starts.
// - readback of deferred fields shows the values of the last cycle.
// - channel, network, clamp pin and range latch only with source off.
// - channel select 0 routes to output 1, 1 to output 2.
// - pull-down on OUT1 follows its bit; resets on.
// - enable/pull-down changes in one frame are ordered with a gap.
// - network select 0 picks network A, 1 picks network B.
// - clamp enable switches the output voltage clamp.
// - clamp pin select 0 takes CL1, 1 takes CL2.
// - range bit 0 symmetric clamp range, 1 asymmetric.
// - fault clear 1 clears latched faults at frame end.
// - clean current field, four bits, resets to zero.
// - amplifier gain field, three bits, resets to zero.
// - capacitance code adds to a fixed 1 pF; resets all ones.
// - capacitance changes only while the source is off.
// - clock period field, reported and applied as 00 in sync mode.
// - heater threshold bit 0 is 250 mV, 1 is 425 mV.
// - nonzero reference pulse codes up to 0x18 run as 0x19.
// - sync mode set mid-cycle aborts the cycle and idles.
// - in sync mode a sync rising edge starts a cycle, clears counter.
// - band-gap pulse field, seven bits, resets to zero.
// - single-bit fields reset to 0 except the pull-down.
// - 64-bit word, msb first, sampled on link clock rising edge.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_defs.svh"
module sensor_config_word_fields (
   input  wire logic       ref_clk_in,         // core clock, 125 MHz
   input  wire logic       sys_rst_in,         // sync reset, high
   input  wire logic       spi_clk_in,         // link clock pin
   input  wire logic       chip_select_n_in,   // link select, low
   input  wire logic       spi_din_in,         // link data in
   input  wire logic       sync_input_in,      // sync pin
   input  wire logic       cycle_start_in,     // free-run cycle start
   input  wire logic       cycle_end_in,       // sequencer cycle done
   output logic            spi_dout_out,       // link data out
   output logic            spi_dout_oe_out,    // link data out enable
   output logic            pump_source_en_out, // pump source on
   output logic            park_c3_out,        // C3 parking active
   output logic            pump_pulldown_out,  // OUT1 pull-down on
   output logic            pump_channel_out,   // 0 ch1, 1 ch2
   output logic            comp_network_out,   // 0 net A, 1 net B
   output logic            clamp_en_out,       // voltage clamp on
   output logic            clamp_pin_out,      // 0 CL1, 1 CL2
   output logic            clamp_asym_out,     // asymmetric range
   output logic [3:0]      clean_current_out,  // clean current code
   output logic [2:0]      gain_out,           // amplifier gain code
   output logic [5:0]      comp_cap_out,       // capacitance code
   output logic [1:0]      meas_period_out,    // clock period code
   output logic            heater_thr_out,     // 0 250 mV, 1 425 mV
   output logic [6:0]      ref_pulse_out,      // effective pulse code
   output logic [6:0]      bandgap_pulse_out,  // band-gap pulse code
   output logic            sync_mode_out,      // synchronized mode
   output logic            meas_start_out,     // cycle start pulse
   output logic            meas_abort_out,     // cycle abort pulse
   output logic            meas_cnt_clr_out,   // counter clear pulse
   output logic            meas_idle_out,      // no cycle running
   output logic            fault_clear_out,    // fault clear pulse
   output logic            spi_fault_out,      // frame fault latched
   output logic            spi_illegal_out     // illegal cmd latched
);
   import cfg_pkg::*;

   cfg_link_if link ();

   serial_word_rx u_rx (
      .ref_clk_in  (ref_clk_in),
      .sys_rst_in  (sys_rst_in),
      .spi_clk_in  (spi_clk_in),
      .cs_n_in     (chip_select_n_in),
      .din_in      (spi_din_in),
      .dout_out    (spi_dout_out),
      .dout_oe_out (spi_dout_oe_out),
      .link        (link)
   );

   cfg_t        pend_r;
   cfg_t        act_r;
   cfg_t        pend_nxt;

   logic        snc_r;
   meas_state_t meas_r;

   logic [2:0]  sy_s;
   logic        seq_en;
   logic        seq_pd;

   logic [63:0] tx_word_r;

   // sync pin: two flops before the edge detector
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in)
         sy_s <= 3'h0;
      else
         sy_s <= {sy_s[1:0], sync_input_in};
   end
   wire sy_rise = sy_s[1] & ~sy_s[2];

   // frame decode
   wire cfg_t frame_cfg = link.rx_word[`CFG_MSB:`CFG_LSB];
   wire ref_pd_req = link.rx_word[`REF_PD_BIT];

   wire cb_ok      = link.rx_word[`CB_MSB:`CB_LSB] == `CB_EXPECT;
   wire frame_good = link.frame_ok & cb_ok;
   wire frame_corrupt = link.frame_bad | (link.frame_ok & ~cb_ok);

   // illegal combinations are refused rather than partly applied
   wire both_on    = frame_cfg.pump_en & (frame_cfg.pd | ref_pd_req);
   wire src_lock   = act_r.pump_en;
   wire clamp_lock = act_r.pump_en & act_r.clamp_en;

   wire src_change = (frame_cfg.chan != pend_r.chan) |
                     (frame_cfg.net  != pend_r.net)  |
                     (frame_cfg.cap  != pend_r.cap);

   wire clamp_change = (frame_cfg.clamp_pin  != pend_r.clamp_pin) |
                       (frame_cfg.clamp_asym != pend_r.clamp_asym);

   wire illegal    = both_on | (src_lock & src_change) |
                     (clamp_lock & clamp_change);
   wire frame_take = frame_good & ~illegal;

   // cycle control
   wire snc_nxt   = frame_take ? frame_cfg.sync_mode_select : snc_r;
   wire running   = meas_r == MEAS_RUN;

   wire abort     = frame_take & frame_cfg.sync_mode_select & ~snc_r & running;
   wire start_req = snc_nxt ? sy_rise : cycle_start_in;
   wire start     = start_req & ~abort;

   wire clr_req   = frame_take & frame_cfg.fclr;

   // pending copy; locked fields hold while the source runs
   always_comb begin
      pend_nxt = pend_r;
      if (frame_take) begin
         pend_nxt      = frame_cfg;
         pend_nxt.fclr = 1'b0;
         if (src_lock) begin
            pend_nxt.chan       = pend_r.chan;
            pend_nxt.net        = pend_r.net;
            pend_nxt.cap        = pend_r.cap;
            pend_nxt.clamp_pin  = pend_r.clamp_pin;
            pend_nxt.clamp_asym = pend_r.clamp_asym;
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         pend_r <= `CFG_RST;
         act_r  <= `CFG_RST;
         snc_r  <= 1'b0;
      end else begin
         pend_r <= pend_nxt;
         snc_r  <= snc_nxt;

         // a frame landing with the start waits for the next cycle
         if (start)
            act_r <= pend_r;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         meas_r           <= MEAS_IDLE;
         meas_start_out   <= 1'b0;
         meas_abort_out   <= 1'b0;
         meas_cnt_clr_out <= 1'b0;
         meas_idle_out    <= 1'b1;
      end else begin
         meas_start_out   <= start;
         meas_abort_out   <= abort;
         meas_cnt_clr_out <= start & snc_nxt;
         meas_idle_out    <= (meas_r == MEAS_IDLE) & ~start;

         case (meas_r)
            MEAS_IDLE:
               if (start)
                  meas_r <= MEAS_RUN;
            MEAS_RUN:
               if (abort)
                  meas_r <= MEAS_IDLE;
               else if (cycle_end_in && !start)
                  meas_r <= MEAS_IDLE;
            default: meas_r <= MEAS_IDLE;
         endcase
      end
   end

   // a refused frame never carries an accepted clear
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         spi_fault_out   <= 1'b0;
         spi_illegal_out <= 1'b0;
         fault_clear_out <= 1'b0;
      end else begin
         fault_clear_out <= clr_req;

         if (frame_corrupt) begin
            spi_fault_out   <= 1'b1;
            spi_illegal_out <= 1'b0;
         end else if (link.frame_ok && illegal) begin
            spi_fault_out   <= 1'b1;
            spi_illegal_out <= 1'b1;
         end else if (clr_req) begin
            spi_fault_out   <= 1'b0;
            spi_illegal_out <= 1'b0;
         end
      end
   end

   pump_power_seq #(
      .DELAY_CYC (`SEQ_DELAY_CYC)
   ) u_seq (
      .ref_clk_in (ref_clk_in),
      .sys_rst_in (sys_rst_in),
      .req_en_in  (act_r.pump_en),
      .req_pd_in  (act_r.pd),
      .en_out     (seq_en),
      .pd_out     (seq_pd)
   );

   // short codes are raised to the least usable pulse
   wire ref_short = (act_r.ref_pulse != `REF_PULSE_OFF) &&
                    (act_r.ref_pulse <= `REF_PULSE_LOW);

   wire [6:0] ref_eff = ref_short ? `REF_PULSE_MIN : act_r.ref_pulse;
   wire [1:0] mcp_eff = snc_r ? `MCP_SYNC : act_r.mcp;

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         pump_source_en_out <= 1'b0;
         park_c3_out        <= 1'b1;
         pump_pulldown_out  <= 1'b1;

         pump_channel_out   <= 1'b0;
         comp_network_out   <= 1'b0;
         clamp_en_out       <= 1'b0;
         clamp_pin_out      <= 1'b0;
         clamp_asym_out     <= 1'b0;

         clean_current_out  <= 4'h0;
         gain_out           <= 3'h0;
         comp_cap_out       <= 6'h3f;
         meas_period_out    <= 2'h0;
         heater_thr_out     <= 1'b0;
         ref_pulse_out      <= 7'h00;
         bandgap_pulse_out  <= 7'h00;

         sync_mode_out      <= 1'b0;
      end else begin
         pump_source_en_out <= seq_en;
         park_c3_out        <= ~seq_en;
         pump_pulldown_out  <= seq_pd;

         pump_channel_out   <= act_r.chan;
         comp_network_out   <= act_r.net;
         clamp_en_out       <= act_r.clamp_en;
         clamp_pin_out      <= act_r.clamp_pin;
         clamp_asym_out     <= act_r.clamp_asym;

         clean_current_out  <= act_r.ccs;
         gain_out           <= act_r.gain;
         comp_cap_out       <= act_r.cap;
         meas_period_out    <= mcp_eff;
         heater_thr_out     <= act_r.stb_thr;
         ref_pulse_out      <= ref_eff;
         bandgap_pulse_out  <= act_r.bg_pulse;

         sync_mode_out      <= snc_r;
      end
   end

   // readback shows the settings in use, the raw pulse code included
   cfg_t rep;
   always_comb begin
      rep      = act_r;
      rep.fclr = 1'b0;
      rep.mcp  = mcp_eff;
      rep.sync_mode_select  = snc_r;
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in)
         tx_word_r <= 64'h0;
      else
         tx_word_r <= {9'h000, rep, `CB_EXPECT, 14'h0000};
   end
   assign link.tx_word = tx_word_r;

endmodule
`default_nettype wire

// ---- common/cfg_defs.svh ----
// constants for the serial configuration word fields (bits 54..16)
// assumes a 125 MHz core clock and a 64-bit input word, msb first
`ifndef CFG_DEFS_SVH
`define CFG_DEFS_SVH

`define FRAME_BITS       64
`define FRAME_CNT_W      10
`define CFG_MSB          54
`define CFG_LSB          16
`define REF_PD_BIT       58
`define CB_MSB           15
`define CB_LSB           14
`define CB_EXPECT        2'h2
`define CFG_RST          39'h10_00fc_0000
`define REF_PULSE_OFF    7'h00
`define REF_PULSE_LOW    7'h18
`define REF_PULSE_MIN    7'h19
`define MCP_SYNC         2'h0
`define CLK_MHZ          125
`define SEQ_DELAY_NS     2000
`define SEQ_DELAY_CYC    ((`SEQ_DELAY_NS * `CLK_MHZ + 999) / 1000)

`endif

// ---- common/cfg_pkg.sv ----
// types shared by the configuration word logic
// the field struct packs exactly onto word bits 54..16
package cfg_pkg;

   typedef struct packed {
      logic       pump_en;
      logic       chan;
      logic       pd;
      logic       net;
      logic       clamp_en;
      logic       clamp_pin;
      logic       clamp_asym;
      logic       fclr;
      logic [3:0] ccs;
      logic [2:0] gain;
      logic [5:0] cap;
      logic [1:0] mcp;
      logic       stb_thr;
      logic [6:0] ref_pulse;
      logic       sync_mode_select;
      logic [6:0] bg_pulse;
   } cfg_t;

   typedef enum logic {SEQ_IDLE, SEQ_WAIT} seq_state_t;
   typedef enum logic {MEAS_IDLE, MEAS_RUN} meas_state_t;

endpackage

// ---- common/cfg_link_if.sv ----
// frame hand-off between the serial receiver and the field logic
// all signals live on the core clock
`timescale 1ns/1ps
`default_nettype none
interface cfg_link_if;
   logic [63:0] rx_word;
   logic        frame_ok;
   logic        frame_bad;
   logic [63:0] tx_word;
   modport rx   (output rx_word, output frame_ok, output frame_bad,
                 input tx_word);
   modport core (input rx_word, input frame_ok, input frame_bad,
                 output tx_word);
endinterface
`default_nettype wire

// ---- src/serial_word_rx.sv ----
// serial word receiver: oversamples clock, select and data pins
// assumes the link clock is much slower than the core clock
`timescale 1ns/1ps
`default_nettype none
`include "cfg_defs.svh"
module serial_word_rx (
   input  wire logic ref_clk_in,     // core clock
   input  wire logic sys_rst_in,     // sync reset, high
   input  wire logic spi_clk_in,     // link clock pin
   input  wire logic cs_n_in,        // chip select pin, low active
   input  wire logic din_in,         // serial data in pin
   output logic      dout_out,       // serial data out
   output logic      dout_oe_out,    // data out drive enable
   cfg_link_if.rx    link            // frame hand-off
);
   logic [2:0]              clk_s, cs_s, din_s;
   logic [63:0]             rx_sh_r, tx_sh_r;
   logic [`FRAME_CNT_W-1:0] cnt_r;
   logic                    frame_ok_r, frame_bad_r;
   wire clk_rise = clk_s[1] & ~clk_s[2];
   wire cs_fall  = ~cs_s[1] & cs_s[2];
   wire cs_rise  = cs_s[1] & ~cs_s[2];
   // a frame may be 64 bits plus whole bytes passed through
   wire len_ok   = (cnt_r >= `FRAME_CNT_W'(`FRAME_BITS)) &&
                   (cnt_r[2:0] == 3'h0);
   wire cnt_max  = &cnt_r;

   assign link.rx_word   = rx_sh_r;
   assign link.frame_ok  = frame_ok_r;
   assign link.frame_bad = frame_bad_r;

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         clk_s <= 3'h0;
         cs_s  <= 3'h7;
         din_s <= 3'h0;
      end else begin
         clk_s <= {clk_s[1:0], spi_clk_in};
         cs_s  <= {cs_s[1:0], cs_n_in};
         din_s <= {din_s[1:0], din_in};
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         rx_sh_r     <= 64'h0;
         tx_sh_r     <= 64'h0;
         cnt_r       <= '0;
         dout_out    <= 1'b0;
         dout_oe_out <= 1'b0;
         frame_ok_r  <= 1'b0;
         frame_bad_r <= 1'b0;
      end else begin
         frame_ok_r  <= cs_rise & len_ok;
         frame_bad_r <= cs_rise & ~len_ok;
         dout_oe_out <= ~cs_s[1];
         if (cs_fall) begin
            cnt_r    <= '0;
            dout_out <= link.tx_word[63];
            tx_sh_r  <= {link.tx_word[62:0], 1'b0};
         end else if (clk_rise && !cs_s[1]) begin
            rx_sh_r  <= {rx_sh_r[62:0], din_s[1]};
            // after the own word the input bits are passed on
            tx_sh_r  <= {tx_sh_r[62:0], din_s[1]};
            dout_out <= tx_sh_r[63];
            if (!cnt_max)
               cnt_r <= cnt_r + `FRAME_CNT_W'(1);
         end
      end
   end
endmodule
`default_nettype wire

// ---- src/pump_power_seq.sv ----
// orders pump source enable against its pull-down with a settle gap
// requests come from the active field copy on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "cfg_defs.svh"
module pump_power_seq #(
   parameter int DELAY_CYC = `SEQ_DELAY_CYC
) (
   input  wire logic ref_clk_in,   // core clock
   input  wire logic sys_rst_in,   // sync reset, high
   input  wire logic req_en_in,    // wanted source enable
   input  wire logic req_pd_in,    // wanted pull-down enable
   output logic      en_out,       // applied source enable
   output logic      pd_out        // applied pull-down enable
);
   import cfg_pkg::*;
   seq_state_t  st_r;
   logic [15:0] wait_r;
   wire up_first = req_en_in & ~en_out & pd_out & ~req_pd_in;
   wire dn_first = ~req_en_in & en_out & ~pd_out & req_pd_in;

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         st_r   <= SEQ_IDLE;
         wait_r <= 16'h0;
         en_out <= 1'b0;
         pd_out <= 1'b1;
      end else begin
         case (st_r)
            SEQ_IDLE: begin
               wait_r <= 16'(DELAY_CYC - 1);
               if (up_first) begin
                  pd_out <= 1'b0;
                  st_r   <= SEQ_WAIT;
               end else if (dn_first) begin
                  en_out <= 1'b0;
                  st_r   <= SEQ_WAIT;
               end else begin
                  en_out <= req_en_in;
                  pd_out <= req_pd_in;
               end
            end
            SEQ_WAIT: begin
               wait_r <= wait_r - 16'h1;
               if (wait_r == 16'h0) begin
                  en_out <= req_en_in;
                  pd_out <= req_pd_in;
                  st_r   <= SEQ_IDLE;
               end
            end
            default: st_r <= SEQ_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// ---- tb/cfg_word_monitor.sv ----
// assertions on the ports of the configuration field block
// assumes one core clock domain and a synchronous high reset
`timescale 1ns/1ps
`default_nettype none
module cfg_word_monitor (
   input wire logic       ref_clk_in,         // core clock
   input wire logic       sys_rst_in,         // sync reset
   input wire logic       chip_select_n_in,   // link select
   input wire logic       spi_dout_oe_out,    // data out enable
   input wire logic       pump_source_en_out, // source on
   input wire logic       park_c3_out,        // parking
   input wire logic       pump_pulldown_out,  // pull-down
   input wire logic [5:0] comp_cap_out,       // cap code
   input wire logic [2:0] gain_out,           // gain code
   input wire logic [1:0] meas_period_out,    // period code
   input wire logic [6:0] ref_pulse_out,      // pulse code
   input wire logic       sync_mode_out,      // sync mode
   input wire logic       meas_start_out,     // start pulse
   input wire logic       meas_abort_out,     // abort pulse
   input wire logic       meas_cnt_clr_out,   // counter clear
   input wire logic       meas_idle_out,      // idle
   input wire logic       fault_clear_out,    // clear pulse
   input wire logic       spi_fault_out       // frame fault
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);
   a_park_tracks_src: assert property (
      park_c3_out == !pump_source_en_out)
      else $error("park wrong");
   a_gain_at_start: assert property (
      $changed(gain_out) |-> $past(meas_start_out))
      else $error("gain early");
   a_cap_src_off: assert property (
      $changed(comp_cap_out) |-> !$past(pump_source_en_out))
      else $error("cap changed");
   a_src_pd_excl: assert property (
      !(pump_source_en_out && pump_pulldown_out))
      else $error("src and pd");
   a_src_after_pd: assert property (
      $fell(pump_pulldown_out) |-> !pump_source_en_out [*8])
      else $error("src too soon");
   a_pd_after_src: assert property (
      $fell(pump_source_en_out) |-> !pump_pulldown_out [*8])
      else $error("pd too soon");
   a_pulse_floor: assert property (
      ref_pulse_out != 7'h00 |-> ref_pulse_out >= 7'h19)
      else $error("pulse low");
   a_sync_period: assert property (
      sync_mode_out && $past(sync_mode_out) |-> meas_period_out == 2'h0)
      else $error("period set");
   a_clr_with_start: assert property (
      meas_cnt_clr_out |-> meas_start_out ##1 sync_mode_out)
      else $error("stray clear");
   a_abort_idles: assert property (
      meas_abort_out |-> !meas_start_out ##1 meas_idle_out)
      else $error("abort busy");
   a_clear_flags: assert property (
      fault_clear_out |-> ##[1:2] !spi_fault_out)
      else $error("fault kept");
   a_oe_off_idle: assert property (
      chip_select_n_in [*4] |-> !spi_dout_oe_out)
      else $error("oe while off");
   c_abort: cover property (meas_abort_out);
   c_clear: cover property (fault_clear_out);
   c_cnt_clr: cover property (meas_cnt_clr_out);
endmodule
bind sensor_config_word_fields cfg_word_monitor cfg_word_monitor_i (
   .ref_clk_in, .sys_rst_in, .chip_select_n_in, .spi_dout_oe_out,
   .pump_source_en_out, .park_c3_out, .pump_pulldown_out, .comp_cap_out,
   .gain_out, .meas_period_out, .ref_pulse_out, .sync_mode_out,
   .meas_start_out, .meas_abort_out, .meas_cnt_clr_out, .meas_idle_out,
   .fault_clear_out, .spi_fault_out);
`default_nettype wire

// ---- tb/cfg_host_model.sv ----
// host controller model: sends one word per go pulse on the link
// link clock runs only inside frames, 80 ns period, own phase
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
   input  wire logic        go_in,    // start a frame
   input  wire logic [63:0] word_in,  // word to send
   input  wire logic [6:0]  nbits_in, // bits to send
   input  wire logic        dout_in,  // device data out
   output logic             sclk_out, // link clock
   output logic             cs_n_out, // select, low
   output logic             din_out,  // device data in
   output logic [63:0]      rd_out,   // captured readback
   output logic             done_out  // frame finished
);
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      din_out = 1'b0;
      done_out = 1'b0;
   end
   always @(posedge go_in) begin
      done_out = 1'b0;
      #13 cs_n_out = 1'b0;
      for (int i = int'(nbits_in) - 1; i >= 0; i--) begin
         din_out = word_in[i];
         #40 rd_out = {rd_out[62:0], dout_in};
         sclk_out = 1'b1;
         #40 sclk_out = 1'b0;
      end
      #40 cs_n_out = 1'b1;
      // released line must not keep showing the last bit
      din_out = ~din_out;
      #100 done_out = 1'b1;
   end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the configuration field block
// host model drives the link; bench drives cycle and sync pins
`timescale 1ns/1ps
`default_nettype none
`include "cfg_defs.svh"
module tb_top;
   import cfg_pkg::*;
   logic ref_clk_in, sys_rst_in, sync_input_in, cycle_start_in, cycle_end_in;
   logic spi_clk_in, chip_select_n_in, spi_din_in, spi_dout_out, go, done;
   logic spi_dout_oe_out, pump_source_en_out, park_c3_out, pump_pulldown_out;
   logic pump_channel_out, comp_network_out, clamp_en_out, clamp_pin_out;
   logic clamp_asym_out, heater_thr_out, sync_mode_out, meas_start_out;
   logic meas_abort_out, meas_cnt_clr_out, meas_idle_out, fault_clear_out;
   logic spi_fault_out, spi_illegal_out;
   logic [3:0]  clean_current_out;
   logic [2:0]  gain_out;
   logic [5:0]  comp_cap_out;
   logic [1:0]  meas_period_out;
   logic [6:0]  ref_pulse_out, bandgap_pulse_out;
   logic [63:0] word, rd;
   int          error_cnt, n_tests, n_abort, n_start, n_clr;
   cfg_t        c;
   wire logic        so = spi_dout_oe_out ? spi_dout_out : 1'bz;
   wire logic [7:0]  flags = {pump_source_en_out, park_c3_out,
      pump_pulldown_out, pump_channel_out, comp_network_out, clamp_en_out,
      clamp_pin_out, clamp_asym_out};
   wire logic [30:0] codes = {clean_current_out, gain_out, comp_cap_out,
      meas_period_out, heater_thr_out, ref_pulse_out, bandgap_pulse_out,
      sync_mode_out};

   sensor_config_word_fields sensor_config_word_fields_i (
      .ref_clk_in, .sys_rst_in, .spi_clk_in, .chip_select_n_in, .spi_din_in,
      .sync_input_in, .cycle_start_in, .cycle_end_in, .spi_dout_out,
      .spi_dout_oe_out, .pump_source_en_out, .park_c3_out, .pump_pulldown_out,
      .pump_channel_out, .comp_network_out, .clamp_en_out, .clamp_pin_out,
      .clamp_asym_out, .clean_current_out, .gain_out, .comp_cap_out,
      .meas_period_out, .heater_thr_out, .ref_pulse_out, .bandgap_pulse_out,
      .sync_mode_out, .meas_start_out, .meas_abort_out, .meas_cnt_clr_out,
      .meas_idle_out, .fault_clear_out, .spi_fault_out, .spi_illegal_out);
   cfg_host_model cfg_host_model_i (.go_in(go), .word_in(word),
      .nbits_in(7'd64 - 7'(4 * int'(c.gain == 3'h1))), .dout_in(so),
      .sclk_out(spi_clk_in), .cs_n_out(chip_select_n_in),
      .din_out(spi_din_in), .rd_out(rd), .done_out(done));

   initial begin
      ref_clk_in = 1'b0;
      forever #4 ref_clk_in = ~ref_clk_in;
   end
   always @(posedge ref_clk_in) begin
      if (meas_start_out === 1'b1) n_start++;
      if (meas_abort_out === 1'b1) n_abort++;
      if (meas_cnt_clr_out === 1'b1) n_clr++;
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      if (error_cnt == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   function automatic logic [63:0] mk(input cfg_t f);
      return {9'h000, f, `CB_EXPECT, 14'h0000};
   endfunction
   // gain code 1 marks the short frame of the length fault
   task automatic send;
      word <= mk(c);
      go <= 1'b1;
      @(posedge ref_clk_in);
      go <= 1'b0;
      @(posedge ref_clk_in);
      for (int i = 0; i < 2000 && done !== 1'b1; i++) @(posedge ref_clk_in);
      if (done !== 1'b1) begin
         error_cnt++;
         tally_and_finish();
      end
      repeat (4) @(posedge ref_clk_in);
   endtask
   task automatic cyc;
      cycle_end_in <= 1'b1;
      @(posedge ref_clk_in);
      cycle_end_in <= 1'b0;
      cycle_start_in <= 1'b1;
      @(posedge ref_clk_in);
      cycle_start_in <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
   endtask
   task automatic t_reset;
      chk(flags, 8'h60);
      chk(codes, 31'h00fc0000);
      chk({meas_idle_out, spi_fault_out, spi_illegal_out}, 3'h4);
      send();
      chk(rd, mk(c));
   endtask
   task automatic t_defer;
      cyc();
      c = {8'h7e, 4'ha, 3'h5, 6'h15, 2'h2, 1'b1, 7'h40, 1'b0, 7'h33};
      send();
      chk(codes, 31'h00fc0000);
      cyc();
      chk(flags, 8'h7f);
      chk(codes, {4'ha, 3'h5, 6'h15, 2'h2, 1'b1, 7'h40, 7'h33, 1'b0});
      send();
      chk(rd, mk(c));
   endtask
   task automatic t_pump;
      c.pump_en = 1'b1;
      c.pd = 1'b0;
      send();
      cyc();
      chk(flags[7:5], 3'h2);
      repeat (240) @(posedge ref_clk_in);
      chk(flags[7:5], 3'h2);
      repeat (20) @(posedge ref_clk_in);
      chk(flags[7:5], 3'h4);
      c.chan = 1'b0;
      send();
      chk({spi_fault_out, spi_illegal_out}, 2'h3);
      cyc();
      chk(pump_channel_out, 1'b1);
      c.chan = 1'b1;
      c.fclr = 1'b1;
      send();
      chk({spi_fault_out, spi_illegal_out}, 2'h0);
      c.fclr = 1'b0;
      c.cap = 6'h01;
      send();
      chk({spi_fault_out, spi_illegal_out}, 2'h3);
      cyc();
      chk(comp_cap_out, 6'h15);
      c.cap = 6'h15;
      c.pump_en = 1'b0;
      c.pd = 1'b1;
      send();
      cyc();
      chk(flags[7:5], 3'h2);
      repeat (260) @(posedge ref_clk_in);
      chk(flags[7:5], 3'h3);
   endtask
   task automatic t_pulse;
      for (int i = 0; i < 3; i++) begin
         c.ref_pulse = 7'h05 + 7'(i * 19);
         send();
         cyc();
         chk(ref_pulse_out, (i < 2) ? 7'h19 : c.ref_pulse);
         send();
         chk(rd[30:24], c.ref_pulse);
      end
   endtask
   task automatic t_length;
      c.gain = 3'h1;
      send();
      chk({spi_fault_out, spi_illegal_out}, 2'h2);
      cyc();
      chk(gain_out, 3'h5);
      c.gain = 3'h5;
      c.fclr = 1'b1;
      send();
      chk(spi_fault_out, 1'b0);
      c.fclr = 1'b0;
   endtask
   task automatic t_sync;
      int s;
      cyc();
      c.sync_mode_select = 1'b1;
      send();
      chk(n_abort, 1);
      chk({meas_idle_out, sync_mode_out, meas_period_out}, 4'hc);
      s = n_start;
      cyc();
      chk(n_start, s);
      sync_input_in <= 1'b1;
      repeat (6) @(posedge ref_clk_in);
      chk({n_clr[3:0], meas_idle_out}, 5'h02);
      sync_input_in <= 1'b0;
   endtask

   initial begin
      sys_rst_in = 1'b1;
      sync_input_in = 1'b0;
      cycle_start_in = 1'b0;
      cycle_end_in = 1'b0;
      go = 1'b0;
      c = cfg_t'(`CFG_RST);
      repeat (5) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      repeat (6) @(posedge ref_clk_in);
      t_reset();
      t_defer();
      t_pump();
      t_pulse();
      t_length();
      t_sync();
      tally_and_finish();
   end
endmodule
`default_nettype wire
